// File: fwd_word_defs.svh
// Register offsets, field positions, reset values and timing counts for the word builder.
`ifndef FWD_WORD_DEFS_SVH
`define FWD_WORD_DEFS_SVH

// Byte offsets of the registers on the bus.
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_RAND 8'h08
`define OFS_SSD_HI 8'h0C
`define OFS_SSD_LO 8'h10
`define OFS_UNIQ 8'h14
`define OFS_BS_RESP 8'h18
`define OFS_CODES 8'h1C
`define OFS_CHAN 8'h20
`define OFS_ORDER 8'h24
`define OFS_RAW 8'h28
`define OFS_WORD 8'h2C
`define OFS_PARITY 8'h30

// Control register fields.
`define CTRL_START 0
`define CTRL_MODE_BITS 1
`define CTRL_VOICE 2
`define CTRL_KIND_LO 4
`define CTRL_TRAIN_LO 8

// Codes register fields.
`define CODES_TYPE_LO 0
`define CODES_DIGCOL_LO 2
`define CODES_SATCOL_LO 4
`define CODES_NDSAT_LO 6
`define CODES_PDSAT_LO 9
`define CODES_ACTION_LO 12
`define CODES_OE 16
`define CODES_EXTFLAG 17
`define CODES_UP 18
`define CODES_DOWN 19
`define CODES_VPOWER_LO 20

// Overhead type codes.
`define OVH_TYPE_GLOBAL 3'h4
`define OVH_TYPE_SYS_FIRST 3'h6
`define OVH_TYPE_SYS_SECOND 3'h7

// Fixed filler value used for every reserved field.
`define FILLER_BIT 1'h0

// Reset value of the control register and the default parity generator polynomial.
`define RST_CTRL 32'h0000_0000
`define PARITY_POLY_DEFAULT 12'hF25

// Bit period on the link and the clock period, both in nanoseconds.
`define BIT_TIME_NS 100000
`define CLK_PERIOD_NS 10
`define BIT_CYCLES (`BIT_TIME_NS / `CLK_PERIOD_NS)

`endif

// File: fwd_word_pkg.sv
// Types shared by the word builder modules.
package fwd_word_pkg;

	// Word kinds the builder can format.
	typedef enum logic [3:0] {
		K_CHAL_A = 4'h0,
		K_CHAL_B = 4'h1,
		K_SSD1 = 4'h2,
		K_SSD2 = 4'h3,
		K_SSD3 = 4'h4,
		K_UNIQ = 4'h5,
		K_BS_CONF = 4'h6,
		K_EXT_PROT = 4'h7,
		K_NCH_ASN = 4'h8,
		K_NMS_ORDER = 4'h9,
		K_SYS_ONE = 4'hA,
		K_SYS_TWO = 4'hB
	} word_kind_type;

	// Builder sequence, Gray coded along idle, build, send.
	typedef enum logic [1:0] {
		S_IDLE = 2'h0,
		S_BUILD = 2'h1,
		S_SEND = 2'h3
	} build_state_type;

endpackage

// File: word_if.sv
// Carrier for a finished word passing from the builder to the serialiser.
`timescale 1ns/100ps
`default_nettype none
interface word_if #(parameter int WIDTH = 40);
	logic [WIDTH-1:0] word; // Data bits followed by parity bits.
	logic valid; // Word offered.
	logic ready; // Serialiser can take it.
	modport src (output word, output valid, input ready);
	modport sink (input word, input valid, output ready);
endinterface
`default_nettype wire

// File: parity_gen.sv
// Parity generator over a data word, result held in a register.
`timescale 1ns/100ps
`default_nettype none
`include "fwd_word_defs.svh"
module parity_gen #(
	parameter int DATA_W = 28,
	parameter int PAR_W = 12,
	parameter logic [11:0] POLY = `PARITY_POLY_DEFAULT
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [DATA_W-1:0] data,
	input wire logic load,
	output logic [PAR_W-1:0] parity,
	output logic done
);
	typedef struct packed {
		logic [PAR_W-1:0] par; // Computed check bits.
		logic done; // One-cycle mark that par is fresh.
	} par_state_type;

	par_state_type s_q, s_d;

	// Divide the data by the generator, most significant bit first.
	always_comb begin
		logic [PAR_W-1:0] r;
		logic fb;
		r = '0;
		fb = 1'b0;
		s_d = s_q;
		s_d.done = 1'b0;
		for (int i = DATA_W - 1; i >= 0; i--) begin
			fb = data[i] ^ r[PAR_W-1];
			r = {r[PAR_W-2:0], 1'b0} ^ (fb ? POLY[PAR_W-1:0] : '0);
		end
		if (load) begin
			s_d.par = r;
			s_d.done = 1'b1;
		end
	end

	// State register.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign parity = s_q.par;
	assign done = s_q.done;
endmodule
`default_nettype wire

// File: word_serializer.sv
// Serialiser that sends a word most significant bit first at the link bit rate.
`timescale 1ns/100ps
`default_nettype none
`include "fwd_word_defs.svh"
module word_serializer #(
	parameter int WIDTH = 40,
	parameter int BIT_CYCLES = `BIT_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	word_if.sink in_w,
	output logic tx_data,
	output logic tx_active,
	output logic word_done
);
	typedef struct packed {
		logic [WIDTH-1:0] shift; // Bits still to go, next one on top.
		logic [7:0] left; // Bits left in the word.
		logic [15:0] timer; // Cycles left in the current bit.
		logic busy; // A word is on the line.
		logic bit_out; // Line level.
		logic done; // End of word pulse.
	} ser_state_type;

	ser_state_type s_q, s_d;

	// Load a word when idle, then hold each bit for one bit period.
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (!s_q.busy) begin
			if (in_w.valid) begin
				s_d.busy = 1'b1;
				s_d.bit_out = in_w.word[WIDTH-1];
				s_d.shift = {in_w.word[WIDTH-2:0], 1'b0};
				s_d.left = 8'(WIDTH - 1);
				s_d.timer = 16'(BIT_CYCLES - 1);
			end
		end else if (s_q.timer != 16'h0000) begin
			s_d.timer = s_q.timer - 16'h0001;
		end else if (s_q.left != 8'h00) begin
			// Next bit; the timer restarts so every bit lasts the same time.
			s_d.bit_out = s_q.shift[WIDTH-1];
			s_d.shift = {s_q.shift[WIDTH-2:0], 1'b0};
			s_d.left = s_q.left - 8'h01;
			s_d.timer = 16'(BIT_CYCLES - 1);
		end else begin
			s_d.busy = 1'b0;
			s_d.bit_out = 1'b0;
			s_d.done = 1'b1;
		end
	end

	// State register.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign in_w.ready = !s_q.busy;
	assign tx_data = s_q.bit_out;
	assign tx_active = s_q.busy;
	assign word_done = s_q.done;
endmodule
`default_nettype wire

// File: fwd_word_builder.sv
// Forward channel signalling word builder with an AHB-Lite register slave.
//
// Register access over AHB-Lite and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "fwd_word_defs.svh"
module fwd_word_builder #(
	parameter int BIT_CYCLES = `BIT_CYCLES,
	parameter logic [11:0] PARITY_POLY = `PARITY_POLY_DEFAULT
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic tx_data,
	output logic tx_active,
	output logic word_done,
	output fwd_word_pkg::build_state_type build_state
);
	import fwd_word_pkg::*;

	localparam int DATA_W = 28; // Information bits in one word.
	localparam int PAR_W = 12; // Check bits appended to every word.
	localparam int WORD_W = DATA_W + PAR_W;

	// All state of the block in one record.
	typedef struct packed {
		logic ready_out; // Bus ready, the slave never inserts waits.
		logic resp; // Bus response, always OKAY.
		logic [31:0] rdata; // Read data for the current data phase.
		logic wr_pend; // A write data phase is in progress.
		logic [7:0] wr_addr; // Offset of that write.
		logic start_pend; // Software asked for a word.
		logic mode_bits; // High: user bits sent verbatim.
		logic voice; // High: voice channel variant of a word.
		logic [3:0] kind; // Word kind to format.
		logic [3:0] train_last; // Index of the final word of the train.
		logic [3:0] train_idx; // Index of the next overhead word of the train, global action or system.
		logic [31:0] rand32; // Authentication random value.
		logic [31:0] ssd_hi; // Upper 32 bits of the SSD random number.
		logic [23:0] ssd_lo; // Lower 24 bits of the SSD random number.
		logic [23:0] uniq; // Unique challenge random number.
		logic [17:0] bs_resp; // Base challenge response.
		logic [22:0] codes; // Small code fields.
		logic [23:0] chan; // Channel number and extended protocol fields.
		logic [22:0] order; // Order fields and mobile id part.
		logic [27:0] raw; // User defined word bits.
		build_state_type fsm; // Builder sequence.
		logic [27:0] word; // Word being sent.
		logic par_load; // Ask the parity generator to run.
		logic push; // Offer the word to the serialiser.
		logic [15:0] sent; // Words handed to the serialiser.
	} top_state_type;

	top_state_type s_q, s_d;
	logic [PAR_W-1:0] par_value; // Check bits from the generator.
	logic par_done; // Check bits fresh.
	logic [DATA_W-1:0] formatted; // Word built from the field registers.

	word_if #(.WIDTH(WORD_W)) link_w ();

	// Field views of the code registers.
	logic [1:0] type_code;
	logic [1:0] digital_colour_code;
	logic [1:0] sat_colour_code;
	logic [2:0] new_dsat_colour_code;
	logic [2:0] present_dsat_colour_code;
	logic [3:0] global_action_code;
	logic odd_even_bit;
	logic extended_protocol_flag;
	logic offset_up_bit;
	logic offset_down_bit;
	logic [2:0] voice_power_code;
	logic [10:0] chan_number;
	logic [4:0] extended_message_length;
	logic [7:0] extended_message_type;
	logic [4:0] local_field;
	logic [2:0] order_qualifier;
	logic [4:0] order_type;
	logic [9:0] mobile_id_second_part;
	logic end_bit;

	// Split the code registers into named fields.
	always_comb begin
		type_code = s_q.codes[`CODES_TYPE_LO +: 2];
		digital_colour_code = s_q.codes[`CODES_DIGCOL_LO +: 2];
		sat_colour_code = s_q.codes[`CODES_SATCOL_LO +: 2];
		new_dsat_colour_code = s_q.codes[`CODES_NDSAT_LO +: 3];
		present_dsat_colour_code = s_q.codes[`CODES_PDSAT_LO +: 3];
		global_action_code = s_q.codes[`CODES_ACTION_LO +: 4];
		odd_even_bit = s_q.codes[`CODES_OE];
		extended_protocol_flag = s_q.codes[`CODES_EXTFLAG];
		offset_up_bit = s_q.codes[`CODES_UP];
		offset_down_bit = s_q.codes[`CODES_DOWN];
		voice_power_code = s_q.codes[`CODES_VPOWER_LO +: 3];
		chan_number = s_q.chan[10:0];
		extended_message_length = s_q.chan[15:11];
		extended_message_type = s_q.chan[23:16];
		local_field = s_q.order[4:0];
		order_qualifier = s_q.order[7:5];
		order_type = s_q.order[12:8];
		mobile_id_second_part = s_q.order[22:13];
		end_bit = (s_q.train_idx >= s_q.train_last);
	end

	// Format the selected word, fields most significant first, filler fixed.
	always_comb begin
		unique case (word_kind_type'(s_q.kind))
			K_CHAL_A: formatted = {type_code, digital_colour_code, global_action_code,
				s_q.rand32[31:16], end_bit, `OVH_TYPE_GLOBAL};
			K_CHAL_B: formatted = {type_code, digital_colour_code, global_action_code,
				s_q.rand32[15:0], end_bit, `OVH_TYPE_GLOBAL};
			// System words take a 20-bit body from the user bits so the word stays 28 wide.
			K_SYS_ONE: formatted = {type_code, digital_colour_code, s_q.raw[23:4],
				end_bit, `OVH_TYPE_SYS_FIRST};
			K_SYS_TWO: formatted = {type_code, digital_colour_code, s_q.raw[23:4],
				end_bit, `OVH_TYPE_SYS_SECOND};
			K_SSD1: formatted = s_q.voice ? {type_code, s_q.ssd_hi[31:8], {2{`FILLER_BIT}}}
				: {type_code, sat_colour_code, s_q.ssd_hi[31:8]};
			K_SSD2: formatted = s_q.voice
				? {type_code, s_q.ssd_hi[7:0], s_q.ssd_lo[23:8], {2{`FILLER_BIT}}}
				: {type_code, sat_colour_code, s_q.ssd_hi[7:0], s_q.ssd_lo[23:8]};
			K_SSD3: formatted = s_q.voice
				? {type_code, s_q.ssd_lo[7:0], {18{`FILLER_BIT}}}
				: {type_code, sat_colour_code, {8{`FILLER_BIT}}, s_q.ssd_lo[7:0],
				{8{`FILLER_BIT}}};
			K_UNIQ: formatted = s_q.voice ? {type_code, {2{`FILLER_BIT}}, s_q.uniq}
				: {type_code, sat_colour_code, s_q.uniq};
			K_BS_CONF: formatted = s_q.voice
				? {type_code, {6{`FILLER_BIT}}, s_q.bs_resp, {2{`FILLER_BIT}}}
				: {type_code, sat_colour_code, {4{`FILLER_BIT}}, s_q.bs_resp,
				{2{`FILLER_BIT}}};
			K_EXT_PROT: formatted = {type_code, sat_colour_code, mobile_id_second_part,
				extended_protocol_flag, extended_message_length, extended_message_type};
			K_NCH_ASN: formatted = {type_code, new_dsat_colour_code, {7{`FILLER_BIT}},
				offset_up_bit, offset_down_bit, voice_power_code,
				chan_number};
			K_NMS_ORDER: formatted = {type_code, new_dsat_colour_code,
				present_dsat_colour_code, extended_protocol_flag, {5{`FILLER_BIT}},
				odd_even_bit, local_field, order_qualifier, order_type};
			default: formatted = {DATA_W{`FILLER_BIT}}; // Unused kind codes.
		endcase
	end

	// Bus slave, register file and word sequence.
	always_comb begin
		logic take;
		logic [7:0] ofs;
		logic mapped;
		take = hsel && htrans[1] && hready;
		ofs = haddr[7:0];
		mapped = (haddr[31:8] == 24'h000000);
		s_d = s_q;
		s_d.ready_out = 1'b1;
		s_d.resp = 1'b0;
		s_d.par_load = 1'b0;
		s_d.wr_pend = take && hwrite && mapped;
		s_d.wr_addr = ofs;
		// Read data is registered at the address phase so it stands in the data phase.
		// A read right after a write to the same register returns the old value.
		if (take && !hwrite && mapped) begin
			unique case (ofs)
				`OFS_CTRL: s_d.rdata = {20'h00000, s_q.train_last, s_q.kind, 1'b0,
					s_q.voice, s_q.mode_bits, s_q.start_pend};
				`OFS_STATUS: s_d.rdata = {s_q.sent, 8'h00, s_q.train_idx,
					1'b0, tx_active, s_q.fsm};
				`OFS_RAND: s_d.rdata = s_q.rand32;
				`OFS_SSD_HI: s_d.rdata = s_q.ssd_hi;
				`OFS_SSD_LO: s_d.rdata = {8'h00, s_q.ssd_lo};
				`OFS_UNIQ: s_d.rdata = {8'h00, s_q.uniq};
				`OFS_BS_RESP: s_d.rdata = {14'h0000, s_q.bs_resp};
				`OFS_CODES: s_d.rdata = {9'h000, s_q.codes};
				`OFS_CHAN: s_d.rdata = {8'h00, s_q.chan};
				`OFS_ORDER: s_d.rdata = {9'h000, s_q.order};
				`OFS_RAW: s_d.rdata = {4'h0, s_q.raw};
				`OFS_WORD: s_d.rdata = {4'h0, s_q.word};
				`OFS_PARITY: s_d.rdata = {20'h00000, par_value};
				default: s_d.rdata = 32'h0000_0000; // Unmapped offsets read zero.
			endcase
		end else if (take) begin
			s_d.rdata = 32'h0000_0000;
		end
		// Writes land at the end of their data phase.
		if (s_q.wr_pend) begin
			unique case (s_q.wr_addr)
				`OFS_CTRL: begin
					s_d.start_pend = s_q.start_pend | hwdata[`CTRL_START];
					s_d.mode_bits = hwdata[`CTRL_MODE_BITS];
					s_d.voice = hwdata[`CTRL_VOICE];
					s_d.kind = hwdata[`CTRL_KIND_LO +: 4];
					s_d.train_last = hwdata[`CTRL_TRAIN_LO +: 4];
					s_d.train_idx = 4'h0; // A new train starts from its first word.
				end
				`OFS_RAND: s_d.rand32 = hwdata;
				`OFS_SSD_HI: s_d.ssd_hi = hwdata;
				`OFS_SSD_LO: s_d.ssd_lo = hwdata[23:0];
				`OFS_UNIQ: s_d.uniq = hwdata[23:0];
				`OFS_BS_RESP: s_d.bs_resp = hwdata[17:0];
				`OFS_CODES: s_d.codes = hwdata[22:0];
				`OFS_CHAN: s_d.chan = hwdata[23:0];
				`OFS_ORDER: s_d.order = hwdata[22:0];
				`OFS_RAW: s_d.raw = hwdata[27:0];
				default: begin
					// Read-only and unmapped offsets ignore writes.
				end
			endcase
		end
		// Builder sequence: format, wait for parity, hand over.
		unique case (s_q.fsm)
			S_IDLE: begin
				if (s_q.start_pend) begin
					s_d.word = s_q.mode_bits ? s_q.raw : formatted;
					s_d.par_load = 1'b1;
					s_d.fsm = S_BUILD;
					if (!s_q.mode_bits && (s_q.kind == K_CHAL_A || s_q.kind == K_CHAL_B
						|| s_q.kind == K_SYS_ONE || s_q.kind == K_SYS_TWO)) begin
						// Step the train; wrap once its final word is out.
						s_d.train_idx = end_bit ? 4'h0 : s_q.train_idx + 4'h1;
					end
				end
			end
			S_BUILD: begin
				if (par_done) begin
					s_d.push = 1'b1;
					s_d.fsm = S_SEND;
				end
			end
			S_SEND: begin
				if (link_w.ready) begin
					// Start is cleared here unless software set it again this cycle.
					s_d.push = 1'b0;
					s_d.start_pend = s_d.start_pend && !(s_q.wr_pend
						&& s_q.wr_addr == `OFS_CTRL && hwdata[`CTRL_START]) ? 1'b0
						: s_d.start_pend;
					s_d.sent = s_q.sent + 16'h0001;
					s_d.fsm = S_IDLE;
				end
			end
		endcase
	end

	// State register.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
			s_q.ready_out <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Check bits follow the data bits; the user can never supply them.
	parity_gen #(.DATA_W(DATA_W), .PAR_W(PAR_W), .POLY(PARITY_POLY)) u_par (
		.ref_clk(ref_clk),
		.rst(rst),
		.data(s_q.word),
		.load(s_q.par_load),
		.parity(par_value),
		.done(par_done)
	);

	assign link_w.word = {s_q.word, par_value};
	assign link_w.valid = s_q.push;

	// Line side of the word.
	word_serializer #(.WIDTH(WORD_W), .BIT_CYCLES(BIT_CYCLES)) u_ser (
		.ref_clk(ref_clk),
		.rst(rst),
		.in_w(link_w),
		.tx_data(tx_data),
		.tx_active(tx_active),
		.word_done(word_done)
	);

	assign hreadyout = s_q.ready_out;
	assign hresp = s_q.resp;
	assign hrdata = s_q.rdata;
	assign build_state = s_q.fsm;
endmodule
`default_nettype wire

// File: fwd_word_builder_chk.sv
// Port checker for the forward word builder, attached by bind.
`timescale 1ns/100ps
`default_nettype none
module fwd_word_builder_chk
	import fwd_word_pkg::*;
#(parameter int BIT_CYCLES = 4) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic tx_data,
	input wire logic tx_active,
	input wire logic word_done,
	input wire build_state_type build_state
);
	int cnt_q; // Cycle within the current bit.
	int len_q; // Cycles the line has been active.
	logic wctl_q; // Control write in its data phase.
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Helper counters; the bit counter restarts with each word so a late edge is caught.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 0;
			len_q <= 0;
			wctl_q <= 1'b0;
		end else begin
			cnt_q <= (!tx_active || cnt_q == BIT_CYCLES - 1) ? 0 : cnt_q + 1;
			len_q <= tx_active ? len_q + 1 : 0;
			wctl_q <= hsel && htrans[1] && hready && hwrite && haddr == 32'h0;
		end
	end
	a_ready_always: assert property (hreadyout) else $error("hreadyout low");
	a_resp_okay: assert property (!hresp) else $error("error response seen");
	a_unmapped_zero: assert property (hsel && htrans[1] && hready && !hwrite
		&& haddr[31:8] != 24'h0 |=> hrdata == 32'h0) else $error("unmapped read not zero");
	a_state_legal: assert property (build_state != 2'h2) else $error("illegal state");
	a_build_send: assert property (build_state == S_BUILD && $past(build_state) == S_IDLE
		|-> ##2 build_state == S_SEND) else $error("send not two edges after build");
	a_bit_hold: assert property (tx_active && $past(tx_active) && $changed(tx_data)
		|-> cnt_q == 0) else $error("bit changed inside its period");
	a_word_length: assert property ($fell(tx_active)
		|-> len_q == 40 * BIT_CYCLES) else $error("word length wrong");
	a_done_pulse: assert property (word_done |=> !word_done) else $error("done too long");
	a_done_follows: assert property ($fell(tx_active) |-> ##[0:2] word_done)
		else $error("done missing after word");
	a_done_idle: assert property (word_done |-> !tx_active) else $error("done while active");
	a_start_build: assert property (wctl_q && hwdata[0] && build_state == S_IDLE && !tx_active
		|-> ##[1:3] build_state == S_BUILD) else $error("start ignored");
	c_word: cover property ($fell(tx_active));
	c_pending: cover property (wctl_q && hwdata[0] && tx_active);
	c_unmapped: cover property (hsel && htrans[1] && haddr[31:8] != 24'h0);
endmodule
bind fwd_word_builder fwd_word_builder_chk #(.BIT_CYCLES(BIT_CYCLES)) chk_u (
	.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .tx_data(tx_data), .tx_active(tx_active),
	.word_done(word_done), .build_state(build_state));
`default_nettype wire

// File: mobile_rx.sv
// Receiving mobile model that samples each word from the serial line.
`timescale 1ns/100ps
`default_nettype none
module mobile_rx #(parameter int BIT_CYCLES = 4) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic tx_data,
	input wire logic tx_active,
	output logic [39:0] rx_word,
	output logic rx_stb
);
	int cnt; // Cycle within the bit.
	int nbits; // Bits taken so far.
	logic [39:0] sh; // Shift register, first bit ends up on top.
	// Sample mid-bit, away from both edges of the bit period.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt <= 0;
			nbits <= 0;
			sh <= 40'h0;
			rx_word <= 40'h0;
			rx_stb <= 1'b0;
		end else begin
			rx_stb <= 1'b0;
			if (!tx_active) begin
				cnt <= 0;
				nbits <= 0;
			end else begin
				cnt <= (cnt == BIT_CYCLES - 1) ? 0 : cnt + 1;
				if (cnt == BIT_CYCLES / 2) begin
					sh <= {sh[38:0], tx_data};
					nbits <= nbits + 1;
					if (nbits == 39) begin
						// Contents are only recorded, so a local field is never acted on.
						rx_word <= {sh[38:0], tx_data};
						rx_stb <= 1'b1;
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: tb_fwd_word_builder.sv
// Self-checking bench for the forward word builder.
`timescale 1ns/100ps
`default_nettype none
`include "fwd_word_defs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_fwd_word_builder;
	import fwd_word_pkg::*;
	localparam int BITC = 4; // Short bit period keeps the run brief.
	// An expected word: verbatim data or a field that must appear somewhere in it.
	typedef struct packed {logic verb; logic same; logic [5:0] w; logic [31:0] v;} exp_type;
	logic ref_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, seed = 32'hA86E4265;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, tx_data, tx_active, word_done, rx_stb;
	logic [31:0] hrdata;
	logic [39:0] rx_word;
	logic [11:0] last_par = 12'h0;
	logic [31:0] rv [0:9]; // Values written to the field registers.
	build_state_type build_state;
	exp_type exp_q[$];
	exp_type mon_e;
	int bad_count = 0, comparisons = 0, nsent = 0;
	always #5 ref_clk = ~ref_clk;
	fwd_word_builder #(.BIT_CYCLES(BITC)) dut_u (.ref_clk(ref_clk), .rst(rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.tx_data(tx_data), .tx_active(tx_active), .word_done(word_done),
		.build_state(build_state));
	mobile_rx #(.BIT_CYCLES(BITC)) rx_u (.ref_clk(ref_clk), .rst(rst), .tx_data(tx_data),
		.tx_active(tx_active), .rx_word(rx_word), .rx_stb(rx_stb));
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// True when the low w bits of v stand as one slice of the data bits.
	function automatic logic has_slice(input logic [27:0] d, input logic [31:0] v,
		input logic [5:0] w);
		logic [31:0] m;
		has_slice = 1'b0;
		m = (32'h1 << w) - 32'h1;
		for (int i = 0; i <= 28 - int'(w); i++) if (((32'(d) >> i) & m) == (v & m)) has_slice = 1'b1;
	endfunction
	function automatic exp_type mk(input logic [5:0] w, input logic [31:0] v);
		return '{1'b0, 1'b0, w, v};
	endfunction
	// Field each kind of word must carry: a slice of the values written earlier, or the fixed type code for system words.
	function automatic exp_type exp_for(input word_kind_type k);
		case (k)
			K_CHAL_A: return mk(6'd16, 32'(rv[2][31:16]));
			K_CHAL_B: return mk(6'd16, 32'(rv[2][15:0]));
			K_SSD1: return mk(6'd24, 32'(rv[3][31:8]));
			K_SSD2: return mk(6'd24, {8'h0, rv[3][7:0], rv[4][23:8]});
			K_SSD3: return mk(6'd8, 32'(rv[4][7:0]));
			K_UNIQ: return mk(6'd24, 32'(rv[5][23:0]));
			K_BS_CONF: return mk(6'd18, 32'(rv[6][17:0]));
			K_EXT_PROT: return mk(6'd8, 32'(rv[8][23:16]));
			K_NCH_ASN: return mk(6'd11, 32'(rv[8][10:0]));
			K_NMS_ORDER: return mk(6'd5, 32'(rv[9][12:8]));
			K_SYS_ONE: return mk(6'd3, 32'(`OVH_TYPE_SYS_FIRST));
			default: return mk(6'd3, 32'(`OVH_TYPE_SYS_SECOND));
		endcase
	endfunction
	// One single transfer; called just after a rising edge, returns at the data edge.
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rdchk(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
		bus(1'b0, a, 32'h0);
		`CHK(rd & m, e & m)
	endtask
	// Step one edge first so a done pulse already seen is not counted twice.
	task automatic wait_done();
		@(posedge ref_clk);
		for (int i = 0; i < 500 && word_done !== 1'b1; i++) @(posedge ref_clk);
		`CHK(word_done, 1'b1)
	endtask
	// Note the expectation, then start the word and let it finish.
	task automatic send(input logic [31:0] ctl, input exp_type e);
		exp_q.push_back(e);
		bus(1'b1, 32'(`OFS_CTRL), ctl);
		wait_done();
		nsent++;
	endtask
	task automatic give_verdict();
		$display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Receiver side: each captured word is matched against the oldest note.
	always @(posedge ref_clk) begin
		if (rx_stb === 1'b1) begin
			`CHK(exp_q.size() > 0, 1'b1)
			if (exp_q.size() > 0) begin
				mon_e = exp_q.pop_front();
				if (mon_e.verb) `CHK(rx_word[39:12], mon_e.v[27:0])
				else `CHK(has_slice(rx_word[39:12], mon_e.v, mon_e.w), 1'b1)
				if (mon_e.same) `CHK(rx_word[11:0], last_par)
				last_par = rx_word[11:0];
			end
		end
	end
	// A hung handshake ends the run as a failure.
	initial begin
		repeat (20000) @(posedge ref_clk);
		bad_count++;
		give_verdict();
	end
	initial begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		rdchk(32'(`OFS_CTRL), `RST_CTRL, 32'hFFFFFFFF);
		bus(1'b1, 32'(`OFS_STATUS), 32'hFFFFFFFF);
		rdchk(32'(`OFS_STATUS), 32'h0, 32'hFFFF0003);
		bus(1'b1, 32'h100, 32'h5A5A5A5A);
		rdchk(32'h100, 32'h0, 32'hFFFFFFFF);
		for (int o = 2; o <= 9; o++) begin
			seed = lfsr_next(seed);
			rv[o] = seed;
			bus(1'b1, 32'(o * 4), seed);
		end
		rdchk(32'(`OFS_CODES), rv[7], 32'h007FFFFF);
		$display("test registers done");
		for (int k = 0; k < 12; k++) send({24'h0, 4'(k), 4'h1}, exp_for(word_kind_type'(k)));
		for (int k = 2; k < 7; k++) send({24'h0, 4'(k), 4'h5}, exp_for(word_kind_type'(k)));
		$display("test formatted words done");
		exp_q.push_back(exp_for(K_CHAL_A));
		exp_q.push_back(exp_for(K_CHAL_B));
		bus(1'b1, 32'(`OFS_CTRL), 32'h01);
		for (int i = 0; i < 50 && build_state !== S_SEND; i++) @(posedge ref_clk);
		bus(1'b1, 32'(`OFS_CTRL), 32'h11);
		wait_done();
		wait_done();
		nsent += 2;
		$display("test pending start done");
		seed = lfsr_next(seed);
		bus(1'b1, 32'(`OFS_RAW), {4'h0, seed[27:0]});
		send(32'h3, '{1'b1, 1'b0, 6'd28, {4'h0, seed[27:0]}});
		bus(1'b1, 32'(`OFS_PARITY), ~rx_word[31:0]);
		send(32'h3, '{1'b1, 1'b1, 6'd28, {4'h0, seed[27:0]}});
		$display("test bits mode done");
		rdchk(32'(`OFS_STATUS), {16'(nsent), 16'h0}, 32'hFFFF0003);
		$display("test word count done");
		`CHK(exp_q.size(), 0)
		give_verdict();
	end
endmodule
`default_nettype wire
